// ==== logic/rtca_map.vh ====
`ifndef RTCA_MAP_VH
`define RTCA_MAP_VH
// register byte addresses
`define RTCA_A_EIE 8'he8
`define RTCA_A_ASS 8'hf2
`define RTCA_A_AS 8'hf3
`define RTCA_A_AM 8'hf4
`define RTCA_A_AH 8'hf5
`define RTCA_A_ISTAT 8'hf6
`define RTCA_A_IMASK 8'hf7
`define RTCA_A_EIP 8'hf8
`define RTCA_A_CC 8'hf9
`define RTCA_A_TSS 8'hfa
`define RTCA_A_TS 8'hfb
`define RTCA_A_TM 8'hfc
`define RTCA_A_TH 8'hfd
`define RTCA_A_D0 8'hfe
`define RTCA_A_D1 8'hff
// clock_control fields
`define RTCA_CC_SS_ME 7
`define RTCA_CC_S_ME 6
`define RTCA_CC_M_ME 5
`define RTCA_CC_H_ME 4
`define RTCA_CC_RE 3
`define RTCA_CC_WE 2
`define RTCA_CC_FLAG 1
`define RTCA_CC_OSC 0
// alarm enable / priority bit in the extended irq registers
`define RTCA_EX_ALARM 5
// irq status / mask fields
`define RTCA_IS_ALARM 0
`define RTCA_IS_SEC 1
// reset values
`define RTCA_RST_8 8'h00
`define RTCA_RST_DAY 16'h0000
// time base
`define RTCA_XTAL_HZ 32768
`define RTCA_SUBSEC_PER_S 256
`define RTCA_PRESC_DIV (`RTCA_XTAL_HZ / `RTCA_SUBSEC_PER_S)
`define RTCA_PRESC_LAST 7'h7f
// wrap points
`define RTCA_SS_LAST 8'hff
`define RTCA_SEC_LAST 6'h3b
`define RTCA_MIN_LAST 6'h3b
`define RTCA_HOUR_LAST 5'h17
`define RTCA_DOW_LAST 3'h6
`endif

// ==== logic/rtca_top.v ====
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "rtca_map.vh"
module rtca_top (
    input wire clk_i,
    input wire rst_b_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire timekeeping_xtal_in_i,
    output reg timekeeping_xtal_out_o,
    output wire alarm_irq_o,
    output wire alarm_irq_priority_o,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////
// address decode helpers

// time and calendar registers share the read/write gating
function is_time_reg;
    input [7:0] a;
    begin
        is_time_reg = (a >= `RTCA_A_TSS);
    end
endfunction

// alarm registers sit in a contiguous block
function is_alarm_reg;
    input [7:0] a;
    begin
        is_alarm_reg = (a >= `RTCA_A_ASS) && (a <= `RTCA_A_AH);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] extended_irq_enable;
reg [7:0] extended_irq_priority;
reg [7:0] cc;
reg [7:0] alarm_subseconds;
reg [5:0] alarm_seconds;
reg [5:0] alarm_minutes;
reg [4:0] alarm_hours;
reg [1:0] irq_status;
reg [1:0] irq_mask;
reg [6:0] presc;
reg [7:0] time_subseconds;
reg [5:0] time_seconds;
reg [5:0] time_minutes;
reg [4:0] time_hours;
reg [2:0] day_of_week;
reg [15:0] day_count;
reg [7:0] snap_ss;
reg [5:0] snap_s;
reg [5:0] snap_m;
reg [7:0] snap_h;
reg [15:0] snap_day;
reg xtal_s1;
reg xtal_s2;
reg xtal_s3;
reg tick_q;
reg sec_q;

wire osc_en;
wire time_we;
wire time_re;
wire xtal_rise;
wire tick;
wire sec_wrap;
wire time_wr;
wire cc_wr;
wire alarm_match;
wire [7:0] hours_reg;
reg [7:0] next_cc;
reg [7:0] rd_mux;

assign osc_en = cc[`RTCA_CC_OSC];
assign time_we = cc[`RTCA_CC_WE];
assign time_re = cc[`RTCA_CC_RE];
assign time_wr = wr_i && time_we && is_time_reg(addr_i);
assign cc_wr = wr_i && (addr_i == `RTCA_A_CC);
assign hours_reg = {day_of_week, time_hours};

////////////////////////////////////////////////////////////////////////
// crystal input and oscillator drive

// two stages before any logic; third stage only for edge detect
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        xtal_s1 <= 1'b0;
        xtal_s2 <= 1'b0;
        xtal_s3 <= 1'b0;
    end else begin
        xtal_s1 <= timekeeping_xtal_in_i;
        xtal_s2 <= xtal_s1;
        xtal_s3 <= xtal_s2;
    end
end

assign xtal_rise = xtal_s2 && !xtal_s3;

// amplifier drive is cut when disabled to spare the backup cell
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        timekeeping_xtal_out_o <= 1'b0;
    end else begin
        timekeeping_xtal_out_o <= osc_en && !xtal_s2;
    end
end

////////////////////////////////////////////////////////////////////////
// prescaler: crystal edges to subsecond ticks

// divide by 32768/256 = 128 crystal cycles per tick
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        presc <= 7'h00;
    end else if (time_wr && (addr_i == `RTCA_A_TSS)) begin
        presc <= 7'h00; // fresh subsecond after a set
    end else if (osc_en && xtal_rise) begin
        presc <= presc + 7'h01;
    end
end

// ticks are dropped while software holds write enable
assign tick = osc_en && xtal_rise && !time_we && (presc == `RTCA_PRESC_LAST);
assign sec_wrap = tick && (time_subseconds == `RTCA_SS_LAST);

////////////////////////////////////////////////////////////////////////
// time of day and calendar counters

// counting never stops for main supply loss, only for osc enable off or write enable set
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        time_subseconds <= `RTCA_RST_8;
        time_seconds <= 6'h00;
        time_minutes <= 6'h00;
        time_hours <= 5'h00;
        day_of_week <= 3'h0;
        day_count <= `RTCA_RST_DAY;
    end else if (time_wr) begin
        case (addr_i)
            `RTCA_A_TSS: begin
                time_subseconds <= wdata_i;
            end
            `RTCA_A_TS: begin
                time_seconds <= wdata_i[5:0];
            end
            `RTCA_A_TM: begin
                time_minutes <= wdata_i[5:0];
            end
            `RTCA_A_TH: begin
                time_hours <= wdata_i[4:0];
                day_of_week <= wdata_i[7:5];
            end
            `RTCA_A_D0: begin
                day_count[7:0] <= wdata_i;
            end
            `RTCA_A_D1: begin
                day_count[15:8] <= wdata_i;
            end
            default: begin
                day_count <= day_count;
            end
        endcase
    end else if (tick) begin
        time_subseconds <= time_subseconds + 8'h01;
        if (sec_wrap) begin
            if (time_seconds == `RTCA_SEC_LAST) begin
                time_seconds <= 6'h00;
                if (time_minutes == `RTCA_MIN_LAST) begin
                    time_minutes <= 6'h00;
                    if (time_hours == `RTCA_HOUR_LAST) begin
                        time_hours <= 5'h00;
                        day_count <= day_count + 16'h0001;
                        if (day_of_week == `RTCA_DOW_LAST) begin
                            day_of_week <= 3'h0;
                        end else begin
                            day_of_week <= day_of_week + 3'h1;
                        end
                    end else begin
                        time_hours <= time_hours + 5'h01;
                    end
                end else begin
                    time_minutes <= time_minutes + 6'h01;
                end
            end else begin
                time_seconds <= time_seconds + 6'h01;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// read snapshot

// frozen while read enable is set, so a carry cannot tear a read
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        snap_ss <= `RTCA_RST_8;
        snap_s <= 6'h00;
        snap_m <= 6'h00;
        snap_h <= `RTCA_RST_8;
        snap_day <= `RTCA_RST_DAY;
    end else if (!time_re) begin
        snap_ss <= time_subseconds;
        snap_s <= time_seconds;
        snap_m <= time_minutes;
        snap_h <= hours_reg;
        snap_day <= day_count;
    end
end

////////////////////////////////////////////////////////////////////////
// alarm comparator

// unselected fields always agree; none selected fires every tick
assign alarm_match = tick_q
    && (!cc[`RTCA_CC_SS_ME] || (time_subseconds == alarm_subseconds))
    && (!cc[`RTCA_CC_S_ME] || (time_seconds == alarm_seconds))
    && (!cc[`RTCA_CC_M_ME] || (time_minutes == alarm_minutes))
    && (!cc[`RTCA_CC_H_ME] || (time_hours == alarm_hours));

// compare one cycle after the tick, once counters have moved
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        tick_q <= 1'b0;
        sec_q <= 1'b0;
    end else begin
        tick_q <= tick;
        sec_q <= sec_wrap;
    end
end

////////////////////////////////////////////////////////////////////////
// alarm and irq configuration registers

// reset stands for the backup supply coming up, not a main reset
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        extended_irq_enable <= `RTCA_RST_8;
        extended_irq_priority <= `RTCA_RST_8;
        alarm_subseconds <= `RTCA_RST_8;
        alarm_seconds <= 6'h00;
        alarm_minutes <= 6'h00;
        alarm_hours <= 5'h00;
        irq_mask <= 2'h0;
    end else if (wr_i) begin
        case (addr_i)
            `RTCA_A_EIE: extended_irq_enable <= wdata_i;
            `RTCA_A_EIP: extended_irq_priority <= wdata_i;
            `RTCA_A_ASS: alarm_subseconds <= wdata_i;
            `RTCA_A_AS: alarm_seconds <= wdata_i[5:0];
            `RTCA_A_AM: alarm_minutes <= wdata_i[5:0];
            `RTCA_A_AH: alarm_hours <= wdata_i[4:0];
            `RTCA_A_IMASK: irq_mask <= wdata_i[1:0];
            default: irq_mask <= irq_mask;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// control register

// flag: a match in the clearing cycle wins over the zero written
always @* begin
    next_cc = cc;
    if (cc_wr) begin
        next_cc = wdata_i;
        next_cc[`RTCA_CC_FLAG] = cc[`RTCA_CC_FLAG] && wdata_i[`RTCA_CC_FLAG];
    end
    if (alarm_match) begin
        next_cc[`RTCA_CC_FLAG] = 1'b1;
    end
end

// this register lives in the backup domain with the counters
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        cc <= `RTCA_RST_8;
    end else begin
        cc <= next_cc;
    end
end

////////////////////////////////////////////////////////////////////////
// sticky status, write one to clear, set wins

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        irq_status <= 2'h0;
    end else begin
        if (wr_i && (addr_i == `RTCA_A_ISTAT)) begin
            irq_status <= (irq_status & ~wdata_i[1:0])
                | {sec_q, alarm_match};
        end else begin
            irq_status <= irq_status | {sec_q, alarm_match};
        end
    end
end

// no clock gating here, so the request holds through Stop mode
assign alarm_irq_o = cc[`RTCA_CC_FLAG] && extended_irq_enable[`RTCA_EX_ALARM];
assign alarm_irq_priority_o = extended_irq_priority[`RTCA_EX_ALARM];
assign irq_o = |(irq_status & irq_mask);

////////////////////////////////////////////////////////////////////////
// read path

// time registers come from the snapshot; reserved bits read zero
always @* begin
    rd_mux = 8'h00;
    if (is_time_reg(addr_i)) begin
        case (addr_i)
            `RTCA_A_TSS: begin
                rd_mux = snap_ss;
            end
            `RTCA_A_TS: begin
                rd_mux = {2'h0, snap_s};
            end
            `RTCA_A_TM: begin
                rd_mux = {2'h0, snap_m};
            end
            `RTCA_A_TH: begin
                rd_mux = snap_h;
            end
            `RTCA_A_D0: begin
                rd_mux = snap_day[7:0];
            end
            default: begin
                rd_mux = snap_day[15:8];
            end
        endcase
    end else if (is_alarm_reg(addr_i)) begin
        case (addr_i)
            `RTCA_A_ASS: rd_mux = alarm_subseconds;
            `RTCA_A_AS: rd_mux = {2'h0, alarm_seconds};
            `RTCA_A_AM: rd_mux = {2'h0, alarm_minutes};
            default: rd_mux = {3'h0, alarm_hours};
        endcase
    end else begin
        case (addr_i)
            `RTCA_A_EIE: begin
                rd_mux = extended_irq_enable;
            end
            `RTCA_A_EIP: begin
                rd_mux = extended_irq_priority;
            end
            `RTCA_A_CC: begin
                rd_mux = cc;
            end
            `RTCA_A_ISTAT: begin
                rd_mux = {6'h00, irq_status};
            end
            `RTCA_A_IMASK: begin
                rd_mux = {6'h00, irq_mask};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end
end

// data valid only in the cycle after the strobe
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        rdata_o <= rd_mux;
    end else begin
        rdata_o <= 8'h00;
    end
end

endmodule

// ==== tb/rtca_checker.sv ====
`timescale 1ns/10ps
`include "rtca_map.vh"
module rtca_checker (
    input wire clk_i,
    input wire rst_b_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire timekeeping_xtal_in_i,
    input wire timekeeping_xtal_out_o,
    input wire alarm_irq_o,
    input wire alarm_irq_priority_o,
    input wire irq_o
);
    reg [5:0] cc_hi;
    reg wd5;
    ////////////////////////////////////////////////////////////////////////////////////
    // shadow of the plain control bits 7:2; the flag moves on its own and the osc enable bit is left out
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cc_hi <= 6'h00;
        end else if (wr_i && addr_i == `RTCA_A_CC) begin
            cc_hi <= wdata_i[7:2];
        end
    end
    // write data bit 5 of the previous cycle, whether written or not, so a one-cycle-later compare sees the written value
    always @(posedge clk_i) begin
        wd5 <= wdata_i[`RTCA_EX_ALARM];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data shown without a read");
    unmapped_zero_a: assert property (
        rd_i && addr_i < `RTCA_A_ASS && addr_i != `RTCA_A_EIE |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (
        rd_i && addr_i == `RTCA_A_CC |=> rdata_o[7:2] == cc_hi)
        else $error("control read-back differs");
    prio_follow_a: assert property (
        wr_i && addr_i == `RTCA_A_EIP |=> alarm_irq_priority_o == wd5)
        else $error("priority output ignores write");
    irq_gate_a: assert property (
        wr_i && addr_i == `RTCA_A_EIE && !wdata_i[`RTCA_EX_ALARM] |=> !alarm_irq_o)
        else $error("alarm irq while disabled");
    flag_sticky_a: assert property ($fell(alarm_irq_o) |-> $past(wr_i) &&
        ($past(addr_i) == `RTCA_A_CC || $past(addr_i) == `RTCA_A_EIE))
        else $error("alarm irq dropped without a write");
    osc_stop_a: assert property (
        wr_i && addr_i == `RTCA_A_CC && !wdata_i[`RTCA_CC_OSC] |-> ##2 !timekeeping_xtal_out_o)
        else $error("amplifier still driven when stopped");
    mask_gate_a: assert property (
        wr_i && addr_i == `RTCA_A_IMASK && wdata_i == 8'h00 |=> !irq_o)
        else $error("irq with all sources masked");
    cover property ($rose(alarm_irq_o));
    cover property ($fell(alarm_irq_o));
    cover property (rd_i && addr_i == `RTCA_A_TSS);
endmodule

bind rtca_top rtca_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timekeeping_xtal_in_i(timekeeping_xtal_in_i),
    .timekeeping_xtal_out_o(timekeeping_xtal_out_o), .alarm_irq_o(alarm_irq_o),
    .alarm_irq_priority_o(alarm_irq_priority_o), .irq_o(irq_o));

// ==== tb/rtca_top_tb.sv ====
`timescale 1ns/10ps
`include "rtca_map.vh"
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[ERR] %0t got %h want %h", $time, g, e); \
    end \
end
module rtca_top_tb;
    // bench crystal is 20 clocks a period so a 128-edge tick is 2560 clocks
    localparam int TICK = 2560;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic xtal = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    wire [7:0] rdata_o;
    wire xo;
    wire airq;
    wire aprio;
    wire irq;
    int mismatches = 0;
    int checks = 0;
    rtca_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timekeeping_xtal_in_i(xtal),
        .timekeeping_xtal_out_o(xo), .alarm_irq_o(airq), .alarm_irq_priority_o(aprio),
        .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////////////
    // system clock and a fast crystal stand-in; the real rate would take far too long
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        forever begin
            repeat (10) @(posedge clk_i);
            xtal <= ~xtal;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask
    task automatic wait_half(input int n);
        repeat (n * TICK / 2) @(posedge clk_i);
        #1;
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`RTCA_A_CC, 8'h00);
        rd(8'hf0, 8'h00);
        wr(`RTCA_A_TS, 8'h12);
        rd(`RTCA_A_TS, 8'h00);
        // one tick before midnight, last weekday, day 0x00ff
        wr(`RTCA_A_CC, 8'h04);
        wr(`RTCA_A_TS, 8'h3b);
        wr(`RTCA_A_TM, 8'h3b);
        wr(`RTCA_A_TH, 8'hd7);
        wr(`RTCA_A_D0, 8'hff);
        wr(`RTCA_A_D1, 8'h00);
        wr(`RTCA_A_TSS, 8'hff);
        rd(`RTCA_A_TS, 8'h3b);
        rd(`RTCA_A_TH, 8'hd7);
        wr(`RTCA_A_ASS, 8'h00);
        wr(`RTCA_A_AS, 8'h00);
        wr(`RTCA_A_AM, 8'h00);
        wr(`RTCA_A_AH, 8'h00);
        wr(`RTCA_A_EIE, 8'h20);
        wr(`RTCA_A_IMASK, 8'h01);
        wr(`RTCA_A_CC, 8'hf1);
        wait_half(3);
        rd(`RTCA_A_TSS, 8'h00);
        rd(`RTCA_A_TS, 8'h00);
        rd(`RTCA_A_TM, 8'h00);
        rd(`RTCA_A_TH, 8'h00);
        rd(`RTCA_A_D0, 8'h00);
        rd(`RTCA_A_D1, 8'h01);
        `CHK(airq, 1'b1)
        `CHK(irq, 1'b1)
        rd(`RTCA_A_CC, 8'hf3);
        rd(`RTCA_A_ISTAT, 8'h03);
        wr(`RTCA_A_IMASK, 8'h00);
        `CHK(irq, 1'b0)
        wr(`RTCA_A_ISTAT, 8'h03);
        rd(`RTCA_A_ISTAT, 8'h00);
        wait_half(2);
        `CHK(airq, 1'b1)
        wr(`RTCA_A_CC, 8'hf1);
        `CHK(airq, 1'b0)
        // no field selected: every tick is an alarm
        wr(`RTCA_A_CC, 8'h01);
        wait_half(2);
        `CHK(airq, 1'b1)
        wr(`RTCA_A_EIE, 8'h00);
        `CHK(airq, 1'b0)
        wr(`RTCA_A_EIE, 8'h20);
        `CHK(airq, 1'b1)
        wr(`RTCA_A_EIP, 8'h20);
        `CHK(aprio, 1'b1)
        // seconds-only match against a second that is not reached
        wr(`RTCA_A_AS, 8'h05);
        wr(`RTCA_A_CC, 8'h41);
        wait_half(4);
        `CHK(airq, 1'b0)
        // stopped clock holds its count
        wr(`RTCA_A_CC, 8'h04);
        wr(`RTCA_A_TSS, 8'h40);
        wr(`RTCA_A_CC, 8'h00);
        wait_half(4);
        rd(`RTCA_A_TSS, 8'h40);
        `CHK(xo, 1'b0)
        wr(`RTCA_A_CC, 8'h01);
        // amplifier drive must follow the crystal once enabled: high while it is low
        @(negedge xtal);
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(xo, 1'b1)
        wait_half(3);
        rd(`RTCA_A_TSS, 8'h41);
        // frozen snapshot while read enable is set
        wr(`RTCA_A_CC, 8'h09);
        wait_half(2);
        rd(`RTCA_A_TSS, 8'h41);
        wr(`RTCA_A_CC, 8'h01);
        rd(`RTCA_A_TSS, 8'h42);
        tally_and_finish();
    end
endmodule
